// File: design/acgc_pkg.sv
package acgc_pkg;
    // register indices; byte address is four times the index
    localparam logic [8:0] ACGC_IDX_LINE_PERIOD  = 9'h007;
    localparam logic [8:0] ACGC_IDX_WIN_START    = 9'h008;
    localparam logic [8:0] ACGC_IDX_WIN_STOP     = 9'h009;
    localparam logic [8:0] ACGC_IDX_CLP_SEL_LO   = 9'h010;
    localparam logic [8:0] ACGC_IDX_CLP_SEL_HI   = 9'h011;
    localparam logic [8:0] ACGC_IDX_GAIN_BASE    = 9'h020;
    localparam logic [8:0] ACGC_IDX_MISC         = 9'h030;
    localparam logic [8:0] ACGC_IDX_CLP_END      = 9'h031;
    localparam logic [8:0] ACGC_IDX_STATUS       = 9'h032;
    localparam logic [8:0] ACGC_IDX_WIN_CTRL     = 9'h18f;
    localparam int         ACGC_ADDR_W           = 11;
    localparam int         ACGC_NCH              = 4;
    localparam int         ACGC_DW               = 16;
    // field positions
    localparam int         ACGC_WIN_EN_BIT       = 1;
    localparam int         ACGC_MISC_FMT_BIT     = 0;
    localparam int         ACGC_MISC_AUTO_BIT    = 1;
    localparam int         ACGC_MISC_SRC_BIT     = 2;
    localparam int         ACGC_MISC_VREF_LSB    = 4;
    // reset values
    localparam logic [1:0]  ACGC_VREF_RST        = 2'h0;
    localparam logic [7:0]  ACGC_DGAIN_RST       = 8'h00;
    localparam logic [15:0] ACGC_WIN_CTRL_RST    = 16'h0002;
    // reference dac codes (millivolt meaning given in the name)
    localparam logic [1:0]  ACGC_VREF_0500MV     = 2'h2;
    localparam logic [1:0]  ACGC_VREF_1100MV     = 2'h3;
    localparam logic [1:0]  ACGC_VREF_1500MV     = 2'h0;
    localparam logic [1:0]  ACGC_VREF_2000MV     = 2'h1;

    typedef enum logic [1:0] {
        ACGC_CLP_PIXEL    = 2'b00,
        ACGC_CLP_LINE     = 2'b01,
        ACGC_CLP_NONE_INT = 2'b10,
        ACGC_CLP_NONE_EXT = 2'b11
    } acgc_clp_mode_t;

    // per-channel gain and offset setting
    typedef struct packed {
        logic [5:0] analog_gain_code;
        logic [7:0] digital_gain_code;
        logic [7:0] offset_correction_code;
    } acgc_chan_cfg_t;

    // sample stream word
    typedef struct packed {
        logic        valid;
        logic [15:0] data;
    } acgc_sample_t;
endpackage : acgc_pkg

// File: design/acgc_dgain.sv
`timescale 1ns/100ps
module acgc_dgain
    import acgc_pkg::*;
(
    input  wire logic         i_sys_clk,
    input  wire logic         i_reset,
    input  wire logic [7:0]   i_gain_code,
    input  wire logic         i_offset_bin,
    input  wire acgc_sample_t i_sample,
    output acgc_sample_t      o_sample
);
    logic signed [16:0] s_in;      // input as signed two's complement
    logic signed [26:0] prod;      // sample times (256 + code)
    logic signed [26:0] rnd;       // rounded product
    logic signed [18:0] scaled;    // product back at sample scale
    logic        [15:0] sat;       // saturated two's complement word

    // product and rounding by half an lsb
    always_comb begin
        s_in   = {i_sample.data[15], i_sample.data};
        prod   = s_in * $signed({2'b00, 9'h100 + {1'b0, i_gain_code}});
        rnd    = prod + 27'sh80;
        scaled = rnd[26:8];
        if (scaled > 19'sh07fff) begin
            sat = 16'h7fff; // clip at positive full scale
        end else if (scaled < -19'sh08000) begin
            sat = 16'h8000; // clip at negative full scale
        end else begin
            sat = scaled[15:0];
        end
    end

    // registered output in the selected format
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            o_sample <= '0;
        end else begin
            o_sample.valid <= i_sample.valid;
            o_sample.data  <= i_offset_bin ? {~sat[15], sat[14:0]} : sat;
        end
    end
endmodule : acgc_dgain

// File: design/acgc_top.sv
// Operation
// - reference dac codes 2,3,0,1 give 0.5-2.0V
// - clamp window bounded by pixel counts after sync
// - group a serves inputs 1,2; b 3,4
// - clamp pulse starts at sample pulse rise
// - auto end gives half sample pulse width
// - manual end uses programmed end position
// - window active in pixel mode uses sample pulse
// - window output high after reset until configured
// - registers at 7,8,9,16,17 and 399 bit1
// - six-bit analog gain code per channel
// - digital gain one plus code/256, reset unity
// - output format two's complement or offset binary
// - offset code eight-bit two's complement per channel
// - clamp mode select per channel, pixel default
// - internal sync pulse one clock, counter clears
//
// Register access over Avalon-MM was left to the implementer.
`timescale 1ns/100ps
module acgc_top
    import acgc_pkg::*;
#(
    parameter int NCH = ACGC_NCH
) (
    input  wire logic                      I_SYS_CLK,
    input  wire logic                      I_RESET,
    input  wire logic [ACGC_ADDR_W-1:0]    I_AVS_ADDRESS,
    input  wire logic                      I_AVS_READ,
    input  wire logic                      I_AVS_WRITE,
    input  wire logic [31:0]               I_AVS_WRITEDATA,
    input  wire logic [3:0]                I_AVS_BYTEENABLE,
    output logic [31:0]                    O_AVS_READDATA,
    output logic                           O_AVS_WAITREQUEST,
    input  wire logic                      I_EXT_LINE_SYNC,
    input  wire logic [1:0]                I_REF_SAMPLE_PULSE,
    input  wire acgc_sample_t              I_SAMPLE,
    output acgc_sample_t                   O_SAMPLE,
    output logic                           O_LINE_SYNC,
    output logic                           O_LINE_CLAMP_WINDOW,
    output logic                           O_CLAMP_PULSE_GROUP_A,
    output logic                           O_CLAMP_PULSE_GROUP_B,
    output logic [NCH-1:0]                 O_CLAMP_ACTIVE,
    output logic [NCH-1:0]                 O_SH_REF_EN,
    output logic [1:0]                     O_INTERNAL_REF_DAC_SELECT,
    output acgc_chan_cfg_t [NCH-1:0]       O_CHAN_CFG
);
    // registers
    logic [15:0]    line_period_count_reg;   // internal line period
    logic [15:0]    window_start_pixel_reg;  // window begin count
    logic [15:0]    window_stop_pixel_reg;   // window end count
    logic [15:0]    clamp_mode_select_lo_reg;
    logic [15:0]    clamp_mode_select_hi_reg;
    logic [15:0]    clamp_window_control_reg;
    logic [15:0]    misc_reg;                // format, auto disable, source, vref
    logic [15:0]    clamp_end_reg;           // manual clamp end in clocks
    acgc_chan_cfg_t chan_cfg_reg [NCH];      // per-channel gain and offset
    // bus
    logic [8:0]     reg_idx;                 // word index
    logic           rd_pend_reg;             // read answer stage
    logic [31:0]    rd_data_next;            // decoded read value
    logic [15:0]    wmask;                   // byte lane mask
    // line timing
    logic [15:0]    pix_cnt_reg;             // pixel counter since sync fall
    logic           line_sync_reg;           // internal sync
    logic           ext_s1_reg;              // sync pin first stage
    logic           ext_s2_reg;              // sync pin second stage
    logic           ext_d_reg;               // sync previous level
    logic           sync_fall;               // sync falling edge
    logic           window_reg;              // window state
    // clamp pulses
    logic [1:0]     shp_s1_reg;              // sample pulse first stage
    logic [1:0]     shp_s2_reg;              // sample pulse second stage
    logic [1:0]     shp_d_reg;               // previous level
    logic [15:0]    shp_w_cnt_reg [2];       // running high width
    logic [15:0]    shp_w_reg [2];           // last measured width
    logic [15:0]    clp_cnt_reg [2];         // time since pulse start
    logic [1:0]     clp_reg;                 // group clamp pulses
    logic           auto_dis;
    logic           src_internal;

    assign reg_idx      = I_AVS_ADDRESS[ACGC_ADDR_W-1:2];
    assign auto_dis     = misc_reg[ACGC_MISC_AUTO_BIT];
    assign src_internal = misc_reg[ACGC_MISC_SRC_BIT];
    assign wmask        = {{8{I_AVS_BYTEENABLE[1]}}, {8{I_AVS_BYTEENABLE[0]}}};

    // waitrequest: writes complete at once, reads after one stage
    assign O_AVS_WAITREQUEST = I_AVS_READ & ~rd_pend_reg;

    // register writes, byte lanes honoured
    always_ff @(posedge I_SYS_CLK) begin
        if (I_RESET) begin
            line_period_count_reg    <= '0;
            window_start_pixel_reg   <= '0;
            window_stop_pixel_reg    <= '0;
            clamp_mode_select_lo_reg <= '0; // pixel clamp default
            clamp_mode_select_hi_reg <= '0;
            clamp_window_control_reg <= ACGC_WIN_CTRL_RST;
            misc_reg                 <= {10'h000, ACGC_VREF_RST, 4'h0};
            clamp_end_reg            <= '0;
            for (int c = 0; c < NCH; c++) begin
                chan_cfg_reg[c] <= '{6'h00, ACGC_DGAIN_RST, 8'h00}; // unity
            end
        end else if (I_AVS_WRITE) begin
            unique case (reg_idx)
                ACGC_IDX_LINE_PERIOD: line_period_count_reg <=
                    (line_period_count_reg & ~wmask) | (I_AVS_WRITEDATA[15:0] & wmask);
                ACGC_IDX_WIN_START: window_start_pixel_reg <=
                    (window_start_pixel_reg & ~wmask) | (I_AVS_WRITEDATA[15:0] & wmask);
                ACGC_IDX_WIN_STOP: window_stop_pixel_reg <=
                    (window_stop_pixel_reg & ~wmask) | (I_AVS_WRITEDATA[15:0] & wmask);
                ACGC_IDX_CLP_SEL_LO: clamp_mode_select_lo_reg <=
                    (clamp_mode_select_lo_reg & ~wmask) | (I_AVS_WRITEDATA[15:0] & wmask);
                ACGC_IDX_CLP_SEL_HI: clamp_mode_select_hi_reg <=
                    (clamp_mode_select_hi_reg & ~wmask) | (I_AVS_WRITEDATA[15:0] & wmask);
                ACGC_IDX_WIN_CTRL: clamp_window_control_reg <=
                    (clamp_window_control_reg & ~wmask) | (I_AVS_WRITEDATA[15:0] & wmask);
                ACGC_IDX_MISC: misc_reg <=
                    (misc_reg & ~wmask) | (I_AVS_WRITEDATA[15:0] & wmask);
                ACGC_IDX_CLP_END: clamp_end_reg <=
                    (clamp_end_reg & ~wmask) | (I_AVS_WRITEDATA[15:0] & wmask);
                default: begin
                    // per-channel gain words; other addresses ignore writes
                    for (int c = 0; c < NCH; c++) begin
                        if (reg_idx == ACGC_IDX_GAIN_BASE + 9'(c)) begin
                            if (I_AVS_BYTEENABLE[0]) begin
                                chan_cfg_reg[c].offset_correction_code <=
                                    I_AVS_WRITEDATA[7:0];
                            end
                            if (I_AVS_BYTEENABLE[1]) begin
                                chan_cfg_reg[c].digital_gain_code <=
                                    I_AVS_WRITEDATA[15:8];
                            end
                            if (I_AVS_BYTEENABLE[2]) begin
                                chan_cfg_reg[c].analog_gain_code <=
                                    I_AVS_WRITEDATA[21:16];
                            end
                        end
                    end
                end
            endcase
        end
    end

    // read decode; unmapped reads return zero
    always_comb begin
        rd_data_next = 32'h0000_0000;
        unique case (reg_idx)
            ACGC_IDX_LINE_PERIOD: rd_data_next[15:0] = line_period_count_reg;
            ACGC_IDX_WIN_START:   rd_data_next[15:0] = window_start_pixel_reg;
            ACGC_IDX_WIN_STOP:    rd_data_next[15:0] = window_stop_pixel_reg;
            ACGC_IDX_CLP_SEL_LO:  rd_data_next[15:0] = clamp_mode_select_lo_reg;
            ACGC_IDX_CLP_SEL_HI:  rd_data_next[15:0] = clamp_mode_select_hi_reg;
            ACGC_IDX_WIN_CTRL:    rd_data_next[15:0] = clamp_window_control_reg;
            ACGC_IDX_MISC:        rd_data_next[15:0] = misc_reg;
            ACGC_IDX_CLP_END:     rd_data_next[15:0] = clamp_end_reg;
            ACGC_IDX_STATUS:      rd_data_next[15:0] = {12'h000, clp_reg,
                                                        window_reg, line_sync_reg};
            default: begin
                for (int c = 0; c < NCH; c++) begin
                    if (reg_idx == ACGC_IDX_GAIN_BASE + 9'(c)) begin
                        rd_data_next = {10'h000, chan_cfg_reg[c].analog_gain_code,
                                        chan_cfg_reg[c].digital_gain_code,
                                        chan_cfg_reg[c].offset_correction_code};
                    end
                end
            end
        endcase
    end

    // read answer one cycle after the request is seen
    always_ff @(posedge I_SYS_CLK) begin
        if (I_RESET) begin
            rd_pend_reg    <= 1'b0;
            O_AVS_READDATA <= '0;
        end else begin
            rd_pend_reg <= I_AVS_READ & ~rd_pend_reg;
            if (I_AVS_READ & ~rd_pend_reg) begin
                O_AVS_READDATA <= rd_data_next;
            end
        end
    end

    // synchronisers for pins
    always_ff @(posedge I_SYS_CLK) begin
        if (I_RESET) begin
            ext_s1_reg <= 1'b0;
            ext_s2_reg <= 1'b0;
            shp_s1_reg <= '0;
            shp_s2_reg <= '0;
        end else begin
            ext_s1_reg <= I_EXT_LINE_SYNC;
            ext_s2_reg <= ext_s1_reg;
            shp_s1_reg <= I_REF_SAMPLE_PULSE;
            shp_s2_reg <= shp_s1_reg;
        end
    end

    // internal sync: one-clock pulse after the programmed count
    // raised one count early so that it stands while the counter holds the period,
    // giving a line of period plus one clocks; >= recovers a counter that is past it
    always_ff @(posedge I_SYS_CLK) begin
        if (I_RESET) begin
            line_sync_reg <= 1'b0;
            ext_d_reg     <= 1'b0;
        end else begin
            ext_d_reg <= ext_s2_reg;
            if (src_internal) begin
                line_sync_reg <= (pix_cnt_reg >= line_period_count_reg - 16'h0001)
                                 & ~line_sync_reg;
            end else begin
                line_sync_reg <= ext_s2_reg;
            end
        end
    end

    assign sync_fall   = src_internal ? line_sync_reg : (ext_d_reg & ~ext_s2_reg);
    assign O_LINE_SYNC = line_sync_reg;

    // pixel counter cleared on the sync edge
    always_ff @(posedge I_SYS_CLK) begin
        if (I_RESET) begin
            pix_cnt_reg <= '0;
        end else if (sync_fall) begin
            pix_cnt_reg <= '0;
        end else if (pix_cnt_reg != 16'hffff) begin
            pix_cnt_reg <= pix_cnt_reg + 16'h0001;
        end
    end

    // window between start and stop counts; high while disabled
    always_ff @(posedge I_SYS_CLK) begin
        if (I_RESET) begin
            window_reg <= 1'b1;
        end else if (!clamp_window_control_reg[ACGC_WIN_EN_BIT]) begin
            window_reg <= 1'b1;
        end else if (pix_cnt_reg == window_start_pixel_reg) begin
            window_reg <= 1'b1;
        end else if (pix_cnt_reg == window_stop_pixel_reg) begin
            window_reg <= 1'b0;
        end
    end
    assign O_LINE_CLAMP_WINDOW = window_reg;

    // per group pixel clamp pulse generation
    for (genvar g = 0; g < 2; g++) begin : g_grp
        always_ff @(posedge I_SYS_CLK) begin
            if (I_RESET) begin
                shp_d_reg[g]     <= 1'b0;
                shp_w_cnt_reg[g] <= '0;
                shp_w_reg[g]     <= '0;
                clp_cnt_reg[g]   <= '0;
                clp_reg[g]       <= 1'b0;
            end else begin
                shp_d_reg[g] <= shp_s2_reg[g];
                // measure sample pulse high width
                if (shp_s2_reg[g] & ~shp_d_reg[g]) begin
                    shp_w_cnt_reg[g] <= 16'h0001;
                end else if (shp_s2_reg[g]) begin
                    shp_w_cnt_reg[g] <= shp_w_cnt_reg[g] + 16'h0001;
                end else if (shp_d_reg[g]) begin
                    shp_w_reg[g] <= shp_w_cnt_reg[g];
                end
                if (shp_s2_reg[g] & ~shp_d_reg[g]) begin
                    clp_reg[g]     <= 1'b1; // start at rise
                    clp_cnt_reg[g] <= 16'h0001;
                end else if (clp_reg[g]) begin
                    clp_cnt_reg[g] <= clp_cnt_reg[g] + 16'h0001;
                    if (!auto_dis && clp_cnt_reg[g] >= {1'b0, shp_w_reg[g][15:1]}) begin
                        clp_reg[g] <= 1'b0; // half width
                    end else if (auto_dis && clp_cnt_reg[g] >= clamp_end_reg) begin
                        clp_reg[g] <= 1'b0; // manual end
                    end
                end
            end
        end
    end
    assign O_CLAMP_PULSE_GROUP_A = clp_reg[0];
    assign O_CLAMP_PULSE_GROUP_B = clp_reg[1];

    // per channel clamp and configuration outputs
    for (genvar c = 0; c < NCH; c++) begin : g_ch
        acgc_clp_mode_t mode;
        logic           grp_clp;
        logic           grp_shp;
        // lo word holds inputs 1,2 and hi word inputs 3,4, two bits each
        assign mode    = acgc_clp_mode_t'(c < 2 ? clamp_mode_select_lo_reg[2*(c%2) +: 2]
                                               : clamp_mode_select_hi_reg[2*(c%2) +: 2]);
        assign grp_clp = clp_reg[c / 2];   // inputs 1,2 group a; 3,4 group b
        assign grp_shp = shp_s2_reg[c / 2];
        always_comb begin
            unique case (mode)
                ACGC_CLP_PIXEL: O_CLAMP_ACTIVE[c] = window_reg ? grp_shp : grp_clp;
                ACGC_CLP_LINE:  O_CLAMP_ACTIVE[c] = window_reg & grp_shp;
                ACGC_CLP_NONE_INT, ACGC_CLP_NONE_EXT: O_CLAMP_ACTIVE[c] = 1'b0;
            endcase
        end
        assign O_SH_REF_EN[c] = (mode == ACGC_CLP_NONE_INT);
        assign O_CHAN_CFG[c]  = chan_cfg_reg[c];
    end

    assign O_INTERNAL_REF_DAC_SELECT = misc_reg[ACGC_MISC_VREF_LSB +: 2];

    // digital gain on channel stream
    acgc_dgain u_dgain (
        .i_sys_clk    (I_SYS_CLK),
        .i_reset      (I_RESET),
        .i_gain_code  (chan_cfg_reg[0].digital_gain_code),
        .i_offset_bin (misc_reg[ACGC_MISC_FMT_BIT]),
        .i_sample     (I_SAMPLE),
        .o_sample     (O_SAMPLE)
    );

    a_sync_one_clk: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
        line_sync_reg && src_internal |=> !line_sync_reg)
        else $error("internal sync longer than one clock");
    a_window_reset: assert property (@(posedge I_SYS_CLK)
        $fell(I_RESET) |-> window_reg)
        else $error("window not high after reset");
    a_window_dis_high: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
        $past(!clamp_window_control_reg[ACGC_WIN_EN_BIT]) |-> window_reg)
        else $error("window low while disabled");
    a_window_start: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
        clamp_window_control_reg[ACGC_WIN_EN_BIT] && pix_cnt_reg == window_start_pixel_reg
        |=> window_reg)
        else $error("window did not open at start count");
    a_clamp_start: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
        $rose(shp_s2_reg[0]) |=> clp_reg[0])
        else $error("clamp pulse missed sample rise");
    a_pixel_window: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
        clamp_mode_select_lo_reg[1:0] == 2'b00 && window_reg
        |-> O_CLAMP_ACTIVE[0] == shp_s2_reg[0])
        else $error("window clamp not from sample pulse");
    a_group_b: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
        clamp_mode_select_hi_reg[1:0] == 2'b00 && !window_reg
        |-> O_CLAMP_ACTIVE[2] == clp_reg[1])
        else $error("input 3 not on group b");
    a_manual_end: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
        auto_dis && clp_reg[0] && !$rose(shp_s2_reg[0]) && clp_cnt_reg[0] >= clamp_end_reg
        |=> !clp_reg[0] || $rose(shp_s2_reg[0]))
        else $error("manual clamp end ignored");
    a_unmapped_zero: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
        I_AVS_READ && !rd_pend_reg && reg_idx == 9'h1ff |=> O_AVS_READDATA == 32'h0)
        else $error("unmapped read not zero");
endmodule : acgc_top

// File: dv/acgc_sensor_model.sv
`timescale 1ns/100ps
module acgc_sensor_model
    import acgc_pkg::*;
(
    input  wire logic        i_sys_clk,
    input  wire logic        i_reset,
    input  wire logic [15:0] i_level,
    output logic             o_ext_line_sync,
    output logic [1:0]       o_ref_sample_pulse,
    output acgc_sample_t     o_sample
);
    logic [5:0] phase_reg; // pixel phase, 64 clocks per line
    // group a pulse 4 clocks, group b 6 clocks, every 16 clocks
    always @(posedge i_sys_clk) begin
        phase_reg <= i_reset ? 6'h00 : phase_reg + 6'h01;
        o_ref_sample_pulse[0] <= phase_reg[3:0] < 4'h4;
        o_ref_sample_pulse[1] <= (phase_reg[3:0] >= 4'h8) && (phase_reg[3:0] < 4'he);
        o_ext_line_sync <= phase_reg < 6'h04; // longer than three clocks
        o_sample <= {1'b1, i_level}; // steady pixel stream
    end
endmodule : acgc_sensor_model

// File: dv/acgc_top_test.sv
`timescale 1ns/100ps
module acgc_top_test
    import acgc_pkg::*;
;
    logic                     clk, rst, rd_en, wr_en, wreq, sync, win, clamp_pulse_group_a, clamp_pulse_group_b;
    logic [10:0]              addr;
    logic [31:0]              wdata, rdata, d;
    logic [15:0]              level;
    logic [1:0]               pulse, vref;
    logic [3:0]               shref;
    logic                     ext_sync;
    acgc_sample_t             smp_in, smp_out;
    acgc_chan_cfg_t [3:0]     cfg;
    int                       n_mismatch, num_checks, w;
    logic [3:0]               act;
    wire  [6:0]               sig = {act[2], act[0], ~sync, sync, win, clamp_pulse_group_b, clamp_pulse_group_a}; // levels
    // clock, 4 ns period
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    acgc_sensor_model acgc_sensor_model_i (.i_sys_clk(clk), .i_reset(rst), .i_level(level),
        .o_ext_line_sync(ext_sync), .o_ref_sample_pulse(pulse), .o_sample(smp_in));
    acgc_top acgc_top_i (.I_SYS_CLK(clk), .I_RESET(rst), .I_AVS_ADDRESS(addr),
        .I_AVS_READ(rd_en), .I_AVS_WRITE(wr_en), .I_AVS_WRITEDATA(wdata),
        .I_AVS_BYTEENABLE(4'hf), .O_AVS_READDATA(rdata), .O_AVS_WAITREQUEST(wreq),
        .I_EXT_LINE_SYNC(ext_sync), .I_REF_SAMPLE_PULSE(pulse), .I_SAMPLE(smp_in),
        .O_SAMPLE(smp_out), .O_LINE_SYNC(sync), .O_LINE_CLAMP_WINDOW(win),
        .O_CLAMP_PULSE_GROUP_A(clamp_pulse_group_a), .O_CLAMP_PULSE_GROUP_B(clamp_pulse_group_b), .O_CLAMP_ACTIVE(act),
        .O_SH_REF_EN(shref), .O_INTERNAL_REF_DAC_SELECT(vref), .O_CHAN_CFG(cfg));
    // compare and count
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    // one avalon transfer, held until waitrequest is seen low at an edge
    task automatic bus(input logic wr, input logic [8:0] idx, input logic [31:0] v);
        @(posedge clk);
        addr <= {idx, 2'b00};
        wdata <= v;
        wr_en <= wr;
        rd_en <= !wr;
        // waitrequest and read data are read at the edge, before it updates them
        forever begin
            @(posedge clk);
            if (wreq === 1'b0) break;
        end
        d = rdata;
        wr_en <= 1'b0;
        rd_en <= 1'b0;
        @(negedge clk); // let the written value settle before callers look
    endtask : bus
    // width of the next high pulse of a measured level
    task automatic width(input int s);
        w = 0;
        for (int k = 0; k < 300 && sig[s]; k++) @(negedge clk);
        for (int k = 0; k < 300 && !sig[s]; k++) @(negedge clk);
        for (int k = 0; k < 300 && sig[s]; k++) begin
            w++;
            @(negedge clk);
        end
    endtask : width
    task automatic conclude;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : conclude
    // watchdog
    initial begin
        #100000;
        n_mismatch++;
        conclude();
    end
    initial begin
        logic [8:0] idx[5] = '{ACGC_IDX_LINE_PERIOD, ACGC_IDX_WIN_START, ACGC_IDX_WIN_STOP,
                               ACGC_IDX_CLP_SEL_LO, ACGC_IDX_CLP_SEL_HI};
        // gain code, format nibble, input level, expected output
        logic [43:0] dg[6] = '{44'h80_0_1000_1800, 44'h80_1_1000_9800, 44'h80_0_7000_7fff,
                               44'h80_1_7000_ffff, 44'h80_0_9000_8000, 44'hff_0_0100_01ff};
        {rst, rd_en, wr_en, addr, wdata, level} = {1'b1, 2'b0, 11'h0, 32'h0, 16'h1000};
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(negedge clk);
        chk(win, 1);
        chk(vref, ACGC_VREF_1500MV);
        chk(smp_out.data, 16'h1000);
        bus(0, ACGC_IDX_WIN_CTRL, 0);
        chk(d, 32'h2);
        bus(0, ACGC_IDX_CLP_SEL_LO, 0);
        chk(d, 0);
        $display("test reset done");
        for (int i = 0; i < 5; i++) begin
            bus(1, idx[i], 32'hbeef_1230 + i);
            bus(0, idx[i], 0);
            chk(d, 32'h1230 + i);
            bus(1, idx[i], 0);
        end
        bus(0, 9'h1ff, 0);
        chk(d, 0);
        for (int c = 0; c < 4; c++) begin
            bus(1, ACGC_IDX_MISC, c << 4);
            chk(vref, c);
        end
        for (int c = 0; c < 4; c++) begin
            bus(1, ACGC_IDX_GAIN_BASE + 9'(c),
                {10'h0, 6'h3f - 6'(c), 8'hff - 8'(c), 8'h80 + 8'(c)});
            chk(cfg[c], {6'h3f - 6'(c), 8'hff - 8'(c), 8'h80 + 8'(c)});
        end
        $display("test registers done");
        foreach (dg[i]) begin
            bus(1, ACGC_IDX_GAIN_BASE, {16'h0, dg[i][43:36], 8'h00});
            bus(1, ACGC_IDX_MISC, {28'h0, dg[i][35:32]});
            level <= dg[i][31:16];
            repeat (6) @(negedge clk);
            chk(smp_out, {1'b1, dg[i][15:0]});
        end
        $display("test digital gain done");
        bus(1, ACGC_IDX_CLP_SEL_LO, 2);
        chk(shref, 4'b0001);
        bus(1, ACGC_IDX_CLP_SEL_LO, 0);
        bus(1, ACGC_IDX_CLP_SEL_HI, 8);
        chk(shref, 4'b1000);
        bus(1, ACGC_IDX_CLP_SEL_HI, 0);
        bus(1, ACGC_IDX_MISC, 0);
        repeat (40) @(posedge clk);
        width(0);
        chk(w, 2);
        width(1);
        chk(w, 3);
        width(5);
        chk(w, 4);
        width(6);
        chk(w, 6);
        bus(1, ACGC_IDX_CLP_END, 3);
        bus(1, ACGC_IDX_MISC, 2);
        width(0);
        chk(w, 3);
        width(1);
        chk(w, 3);
        $display("test clamp pulses done");
        bus(1, ACGC_IDX_LINE_PERIOD, 20);
        bus(1, ACGC_IDX_WIN_CTRL, 32'h2); // window state as second step
        bus(1, ACGC_IDX_WIN_START, 5); // window over dummy pixels
        bus(1, ACGC_IDX_WIN_STOP, 10);
        bus(1, ACGC_IDX_MISC, 4);
        width(3);
        chk(w, 1);
        width(4);
        chk(w, 20);
        width(2);
        chk(w, 5);
        bus(1, ACGC_IDX_WIN_CTRL, 0);
        repeat (30) @(negedge clk);
        chk(win, 1);
        $display("test line timing done");
        conclude();
    end
endmodule : acgc_top_test
